// file: rtl/vrg_pkg.sv
// Constants and types shared by the velocity ramp generator
//
// Overview of operation
// - Ramp shape 3 gives jerk-limited ramps bounded by the four jerk limits.
// - Ramp shape 0, the reset default, gives ramps with unlimited jerk.
// - Commanded speed is capped at min of max profile speed and max motor speed.
// - Halt holds motor stopped; brake on decel ramp, restart on accel ramp.
// - In velocity mode status bit 11 flags a target outside the speed limits.
// - Speeds scale to rpm by multiplier over divisor of the speed unit ratio.
// - Acceleration rate is speed change divided by time in seconds.
// - In velocity mode, a target below the clamp minimum is raised to that minimum.
// - In velocity mode, a target above the clamp maximum is lowered to that maximum.
// - A separate quick-stop ramp exists, laid out like the acceleration ramp.
// - A configurable offset in user units is added to the speed setpoint.
// - Ramp output tracks the target within speed and acceleration limits.
// - Status bit 11 is set one cycle after any speed or rate limit acts, in velocity mode run state only.
// - Plain velocity mode never uses jerk-limited ramps.
// - Ramp output speed and measured speed are readable for monitoring.
// - Four jerk limit values are held for jerk-limited ramps.
// - A positioning move arrives at its target at the configured end speed.
// - Positioning acceleration and normal braking never exceed their maximum settings; quick-stop braking is not capped.
// - Quick-stop-active state brakes with the emergency-stop deceleration.
// - Positions past the range limits wrap back by one span for an endless axis.
`default_nettype none
package vrg_pkg;
    // 100 MHz clock
    localparam logic [31:0] CLK_HZ = 32'h05F5_E100;
    localparam logic [31:0] US_PER_S = 32'h000F_4240;
    // Jerk limits act once per 1000 us
    localparam logic [31:0] JERK_TICK_US = 32'h0000_03E8;
    localparam logic [31:0] JERK_TICK_CYC = (CLK_HZ / US_PER_S) * JERK_TICK_US;
    localparam logic [7:0] MODE_POS = 8'h01;
    localparam logic [7:0] MODE_VEL = 8'h02;
    localparam logic [7:0] MODE_PVEL = 8'h03;
    localparam logic [15:0] PROF_TRAP = 16'h0000;
    localparam logic [15:0] PROF_JERK = 16'h0003;
    localparam int HALT_BIT = 8;
    localparam int LIMIT_BIT = 11;
    localparam logic [15:0] RST_STATUS = 16'h0000;
    localparam logic [15:0] RST_PROFILE = PROF_TRAP;
    localparam logic [15:0] ONE_SECOND = 16'h0001;
    // Jerk entry order: accel start, accel end, decel start, decel end
    localparam int JERK_ACC_UP = 0;
    localparam int JERK_ACC_DN = 1;
    localparam int JERK_DEC_UP = 2;
    localparam int JERK_DEC_DN = 3;

    typedef struct packed {
        logic [31:0] dspeed;
        logic [15:0] dtime;
    } vrg_ramp_type;

    typedef struct packed {
        logic signed [31:0] lo;
        logic signed [31:0] hi;
    } vrg_range_type;

    typedef logic [3:0][31:0] vrg_jerk_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_HALT = 2'b11,
        ST_QSTOP = 2'b10
    } vrg_state_type;
endpackage
`default_nettype wire

// file: rtl/vrg_rate_acc.sv
// Fractional accumulator turning a speed-per-time ramp into unit steps
`default_nettype none
module vrg_rate_acc #(
    parameter int unsigned ACC_W = 64
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_clear,
    input wire logic [31:0] i_delta,
    input wire logic [15:0] i_secs,
    output logic o_step
);
    import vrg_pkg::*;

    logic [ACC_W-1:0] acc_q;
    logic [ACC_W-1:0] thr;
    logic [ACC_W-1:0] sum;
    logic [ACC_W-1:0] rem;

    // One unit per second-slice: delta units are earned per secs*CLK_HZ cycles
    always_comb begin
        thr = ACC_W'(i_secs) * ACC_W'(CLK_HZ);
        sum = acc_q + ACC_W'(i_delta);
        rem = sum - thr;
    end

    // At most one unit per cycle; excess credit is dropped so acc never overflows
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            acc_q <= '0;
            o_step <= 1'b0;
        end else if (i_clear || i_delta == '0) begin
            acc_q <= '0;
            o_step <= 1'b0;
        end else if (sum >= thr) begin
            acc_q <= (rem >= thr) ? '0 : rem;
            o_step <= 1'b1;
        end else begin
            acc_q <= sum;
            o_step <= 1'b0;
        end
    end
endmodule // vrg_rate_acc
`default_nettype wire

// file: rtl/vrg_ramp_gen.sv
// Velocity ramp generator top: setpoint path, ramp selection, jerk and status
`default_nettype none
module vrg_ramp_gen (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [7:0] i_operating_mode_select,
    input wire logic [15:0] i_controlword,
    input wire logic i_quick_stop_active,
    input wire logic signed [31:0] i_target_speed,
    input wire logic signed [31:0] i_speed_offset,
    input wire logic [31:0] i_speed_mult,
    input wire logic [31:0] i_speed_div,
    input wire vrg_pkg::vrg_range_type i_vel_clamp,
    input wire vrg_pkg::vrg_ramp_type i_vel_accel,
    input wire vrg_pkg::vrg_ramp_type i_vel_decel,
    input wire vrg_pkg::vrg_ramp_type i_vel_qstop,
    input wire logic [31:0] i_max_profile_speed,
    input wire logic [31:0] i_max_motor_speed,
    input wire logic [31:0] i_profile_speed,
    input wire logic signed [31:0] i_end_speed,
    input wire logic i_pos_approach,
    input wire logic [31:0] i_prof_accel,
    input wire logic [31:0] i_prof_decel,
    input wire logic [31:0] i_qstop_decel,
    input wire logic [31:0] i_max_accel,
    input wire logic [31:0] i_max_decel,
    input wire logic [15:0] i_profile_type,
    input wire vrg_pkg::vrg_jerk_type i_jerk,
    input wire vrg_pkg::vrg_range_type i_pos_range,
    input wire logic signed [31:0] i_demand_pos,
    input wire logic signed [31:0] i_measured_speed,
    output logic signed [31:0] o_ramp_output_speed,
    output logic signed [31:0] o_measured_speed,
    output logic signed [31:0] o_setpoint_speed,
    output logic signed [31:0] o_demand_pos,
    output logic [15:0] o_statusword,
    output logic o_jerk_active
);
    import vrg_pkg::*;

    function automatic logic [31:0] umin(input logic [31:0] a, input logic [31:0] b);
        umin = (a < b) ? a : b;
    endfunction

    function automatic logic [31:0] mag(input logic signed [31:0] v);
        mag = v[31] ? 32'(-v) : 32'(v);
    endfunction

    // ------------------------------------------------------------
    // Configuration capture
    // ------------------------------------------------------------
    logic [15:0] prof_q;
    logic is_vel;
    logic is_pos;
    logic mode_ok;
    logic jerk_on;

    // Ramp shape register gives trapezoid until software selects otherwise
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prof_q <= RST_PROFILE;
        end else begin
            prof_q <= i_profile_type;
        end
    end

    always_comb begin
        is_vel = (i_operating_mode_select == MODE_VEL);
        is_pos = (i_operating_mode_select == MODE_POS);
        mode_ok = is_vel || is_pos || (i_operating_mode_select == MODE_PVEL);
        // Plain velocity mode is always trapezoidal
        jerk_on = (prof_q == PROF_JERK) && !is_vel;
    end

    // ------------------------------------------------------------
    // Setpoint path
    // ------------------------------------------------------------
    logic signed [31:0] sp_user;
    logic signed [31:0] sp_off;
    logic sp_neg;
    logic [31:0] sp_mag;
    logic [31:0] clamp_mag;
    logic [63:0] prod;
    logic [31:0] div_eff;
    logic [31:0] rpm_mag;
    logic [31:0] cap;
    logic [31:0] cap_mag;
    logic clamp_hit;
    logic cap_hit;
    logic signed [31:0] sp_run;

    always_comb begin
        sp_user = (is_pos && i_pos_approach) ? i_end_speed : i_target_speed;
        sp_off = 32'(sp_user + i_speed_offset);
        sp_neg = sp_off[31];
        sp_mag = mag(sp_off);
        clamp_mag = sp_mag;
        clamp_hit = 1'b0;
        // Clamp acts on the amount in user units, only in velocity mode
        if (is_vel && sp_mag < 32'(i_vel_clamp.lo)) begin
            clamp_mag = 32'(i_vel_clamp.lo);
            clamp_hit = 1'b1;
        end else if (is_vel && sp_mag > 32'(i_vel_clamp.hi)) begin
            clamp_mag = 32'(i_vel_clamp.hi);
            clamp_hit = 1'b1;
        end
        // A zero divisor would be meaningless; treated as one
        div_eff = (i_speed_div == '0) ? 32'h0000_0001 : i_speed_div;
        prod = 64'(clamp_mag) * 64'(i_speed_mult);
        rpm_mag = 32'(prod / 64'(div_eff));
        cap = umin(i_max_profile_speed, i_max_motor_speed);
        if (is_pos) begin
            cap = umin(cap, i_profile_speed);
        end
        cap_hit = (rpm_mag > cap);
        cap_mag = cap_hit ? cap : rpm_mag;
        sp_run = sp_neg ? 32'(-$signed(cap_mag)) : $signed(cap_mag);
    end

    // ------------------------------------------------------------
    // Power and halt state machine
    // ------------------------------------------------------------
    vrg_state_type state_q;
    vrg_state_type state_d;

    always_comb begin
        case (1'b1)
            i_quick_stop_active: state_d = ST_QSTOP;
            !mode_ok: state_d = ST_IDLE;
            i_controlword[HALT_BIT]: state_d = ST_HALT;
            default: state_d = ST_RUN;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------
    // Ramp target and rate selection
    // ------------------------------------------------------------
    logic signed [31:0] out_q;
    logic signed [31:0] sp_q;
    logic signed [31:0] goal;
    logic accel;
    logic [1:0] sel;
    logic [1:0] sel_q;
    vrg_ramp_type ramp;

    // Setpoint is registered so each output step sees a settled target
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sp_q <= '0;
        end else begin
            sp_q <= sp_run;
        end
    end

    always_comb begin
        case (state_q)
            ST_RUN: goal = sp_q;
            ST_HALT: goal = '0;
            ST_QSTOP: goal = '0;
            ST_IDLE: goal = '0;
            default: goal = '0;
        endcase
        // Away from zero, or through zero from standstill, is acceleration
        accel = (out_q == '0) ||
                ((goal[31] == out_q[31]) && (mag(goal) > mag(out_q)));
        if (state_q == ST_QSTOP) begin
            sel = 2'b10;
        end else if (accel) begin
            sel = 2'b00;
        end else begin
            sel = 2'b01;
        end
        ramp = '0;
        if (is_vel) begin
            case (sel)
                2'b00: ramp = i_vel_accel;
                2'b01: ramp = i_vel_decel;
                2'b10: ramp = i_vel_qstop;
                default: ramp = i_vel_decel;
            endcase
        end else begin
            ramp.dtime = ONE_SECOND;
            case (sel)
                2'b00: ramp.dspeed = umin(i_prof_accel, i_max_accel);
                2'b01: ramp.dspeed = umin(i_prof_decel, i_max_decel);
                2'b10: ramp.dspeed = i_qstop_decel;
                default: ramp.dspeed = i_prof_decel;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Jerk limiter on the rate
    // ------------------------------------------------------------
    logic [31:0] jtick_q;
    logic jtick;
    logic [31:0] rate_q;
    logic [31:0] rate_goal;
    logic [31:0] jup;
    logic [31:0] jdn;
    logic [31:0] eff_rate;
    logic [32:0] rate_up;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            jtick_q <= '0;
        end else if (jtick_q >= JERK_TICK_CYC - 32'h0000_0001) begin
            jtick_q <= '0;
        end else begin
            jtick_q <= jtick_q + 32'h0000_0001;
        end
    end

    always_comb begin
        jtick = (jtick_q == '0);
        rate_goal = (out_q == goal) ? '0 : ramp.dspeed;
        jup = accel ? i_jerk[JERK_ACC_UP] : i_jerk[JERK_DEC_UP];
        jdn = accel ? i_jerk[JERK_ACC_DN] : i_jerk[JERK_DEC_DN];
        rate_up = 33'(rate_q) + 33'(jup);
        eff_rate = jerk_on ? umin(rate_q, ramp.dspeed) : ramp.dspeed;
    end

    // Rate moves toward its goal by at most one jerk step per tick
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rate_q <= '0;
        end else if (!jerk_on) begin
            rate_q <= ramp.dspeed;
        end else if (jtick && rate_q < rate_goal) begin
            rate_q <= (rate_up > 33'(rate_goal)) ? rate_goal : rate_up[31:0];
        end else if (jtick && rate_q > rate_goal) begin
            rate_q <= (rate_q - rate_goal > jdn) ? rate_q - jdn : rate_goal;
        end
    end

    // ------------------------------------------------------------
    // Ramp stepping
    // ------------------------------------------------------------
    logic step;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sel_q <= 2'b00;
        end else begin
            sel_q <= sel;
        end
    end

    // Credit restarts when the ramp changes so one ramp never spends another's
    vrg_rate_acc u_rate_acc (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_clear(sel != sel_q),
        .i_delta(eff_rate),
        .i_secs(ramp.dtime),
        .o_step(step)
    );

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            out_q <= '0;
        end else if (step && out_q < goal) begin
            out_q <= out_q + 32'sh0000_0001;
        end else if (step && out_q > goal) begin
            out_q <= out_q - 32'sh0000_0001;
        end
    end

    // ------------------------------------------------------------
    // Status and monitoring
    // ------------------------------------------------------------
    logic limit_d;

    always_comb begin
        limit_d = 1'b0;
        if (is_vel && state_q == ST_RUN) begin
            // Rate limiting counts as a limit as long as output lags target
            limit_d = clamp_hit || cap_hit || (out_q != sp_q);
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_statusword <= RST_STATUS;
        end else begin
            o_statusword <= RST_STATUS;
            o_statusword[LIMIT_BIT] <= limit_d;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_ramp_output_speed <= '0;
            o_measured_speed <= '0;
            o_setpoint_speed <= '0;
            o_jerk_active <= 1'b0;
        end else begin
            o_ramp_output_speed <= out_q;
            o_measured_speed <= i_measured_speed;
            o_setpoint_speed <= sp_q;
            o_jerk_active <= jerk_on;
        end
    end

    // ------------------------------------------------------------
    // Position wrap
    // ------------------------------------------------------------
    logic signed [32:0] span;
    logic signed [31:0] pos_w;

    // One span of correction per cycle; positions further out wrap partly
    always_comb begin
        span = 33'(i_pos_range.hi) - 33'(i_pos_range.lo) + 33'sh0_0000_0001;
        pos_w = i_demand_pos;
        if (i_pos_range.hi > i_pos_range.lo) begin
            if (i_demand_pos > i_pos_range.hi) begin
                pos_w = 32'(33'(i_demand_pos) - span);
            end else if (i_demand_pos < i_pos_range.lo) begin
                pos_w = 32'(33'(i_demand_pos) + span);
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_demand_pos <= '0;
        end else begin
            o_demand_pos <= pos_w;
        end
    end
endmodule // vrg_ramp_gen
`default_nettype wire

// file: test/vrg_ramp_gen_monitor.sv
// Port-level checker for the velocity ramp generator, bound to its top
`default_nettype none
module vrg_ramp_gen_monitor (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [7:0] i_operating_mode_select,
    input wire logic [15:0] i_controlword,
    input wire logic i_quick_stop_active,
    input wire logic signed [31:0] i_target_speed,
    input wire logic signed [31:0] i_speed_offset,
    input wire vrg_pkg::vrg_range_type i_vel_clamp,
    input wire logic [15:0] i_profile_type,
    input wire vrg_pkg::vrg_range_type i_pos_range,
    input wire logic signed [31:0] i_demand_pos,
    input wire logic signed [31:0] i_measured_speed,
    input wire logic signed [31:0] o_ramp_output_speed,
    input wire logic signed [31:0] o_measured_speed,
    input wire logic signed [31:0] o_demand_pos,
    input wire logic [15:0] o_statusword,
    input wire logic o_jerk_active
);
    timeunit 1ns;
    timeprecision 1ps;
    import vrg_pkg::*;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);
    logic stop;
    logic vel;
    logic over;
    logic in_rng;
    assign stop = i_controlword[HALT_BIT] | i_quick_stop_active;
    assign vel = i_operating_mode_select == MODE_VEL;
    assign over = i_target_speed + i_speed_offset > i_vel_clamp.hi;
    // An empty wrap window (hi <= lo) means no wrapping at all
    assign in_rng = i_pos_range.hi <= i_pos_range.lo ||
        (i_demand_pos >= i_pos_range.lo && i_demand_pos < i_pos_range.hi);
    chk_meas_delay: assert property (
        $past(i_rst_n) && $past(i_rst_n, 2) |-> o_measured_speed == $past(i_measured_speed))
        else $error("measured speed not one cycle late");
    chk_limit_clamp: assert property (
        (vel && !stop && over)[*3] |=> o_statusword[LIMIT_BIT])
        else $error("limit flag missing above clamp");
    chk_limit_mode: assert property (
        (!vel)[*3] |=> !o_statusword[LIMIT_BIT])
        else $error("limit flag outside velocity mode");
    chk_limit_halt: assert property (
        stop[*3] |=> !o_statusword[LIMIT_BIT])
        else $error("limit flag while stopped");
    chk_jerk_vel: assert property (
        vel[*3] |=> !o_jerk_active)
        else $error("jerk shaping in velocity mode");
    chk_jerk_on: assert property (
        (i_profile_type == PROF_JERK && i_operating_mode_select == MODE_POS)[*3] |=> o_jerk_active)
        else $error("jerk shaping not active");
    chk_ramp_slope: assert property (
        $past(i_rst_n) |-> (o_ramp_output_speed - $past(o_ramp_output_speed))
            inside {32'hFFFF_FFFF, 32'h0000_0000, 32'h0000_0001})
        else $error("ramp step above one per cycle");
    chk_brake_dir: assert property (
        stop[*4] |=> (!o_ramp_output_speed[31] ? o_ramp_output_speed <= $past(o_ramp_output_speed)
            : o_ramp_output_speed >= $past(o_ramp_output_speed)))
        else $error("speed grows while braking");
    chk_pos_pass: assert property (
        $past(i_rst_n) && $past(i_rst_n, 2) && $past(in_rng) |-> o_demand_pos == $past(i_demand_pos))
        else $error("in-range position altered");
endmodule // vrg_ramp_gen_monitor

bind vrg_ramp_gen vrg_ramp_gen_monitor u_monitor (
    .i_clk, .i_rst_n, .i_operating_mode_select, .i_controlword, .i_quick_stop_active, .i_target_speed,
    .i_speed_offset, .i_vel_clamp, .i_profile_type, .i_pos_range, .i_demand_pos, .i_measured_speed,
    .o_ramp_output_speed, .o_measured_speed, .o_demand_pos, .o_statusword, .o_jerk_active
);
`default_nettype wire

// file: test/vrg_host.sv
// Host software model: mode select, halt bit and deceleration setting
`default_nettype none
module vrg_host (
    input wire logic [7:0] i_mode,
    input wire logic i_halt,
    input wire logic signed [31:0] i_dec_rpm,
    output logic [7:0] o_mode,
    output logic [15:0] o_controlword,
    output var vrg_pkg::vrg_ramp_type o_decel
);
    timeunit 1ns;
    timeprecision 1ps;
    import vrg_pkg::*;
    assign o_mode = i_mode;
    assign o_controlword = {7'h00, i_halt, 8'h00};
    // Callers may hand a signed rate; the host only ever writes its magnitude
    assign o_decel = '{dspeed: (i_dec_rpm < 0) ? -i_dec_rpm : i_dec_rpm, dtime: ONE_SECOND};
endmodule // vrg_host
`default_nettype wire

// file: test/vrg_ramp_gen_bench.sv
// Self-checking bench for the velocity ramp generator
`default_nettype none
module vrg_ramp_gen_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import vrg_pkg::*;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [7:0] i_operating_mode_select;
    logic [15:0] i_controlword, i_profile_type;
    logic i_quick_stop_active, i_pos_approach;
    logic signed [31:0] i_target_speed, i_speed_offset, i_end_speed, i_demand_pos, i_measured_speed;
    logic [31:0] i_speed_mult, i_speed_div, i_max_profile_speed, i_max_motor_speed, i_profile_speed;
    logic [31:0] i_prof_accel, i_prof_decel, i_qstop_decel, i_max_accel, i_max_decel;
    vrg_range_type i_vel_clamp, i_pos_range;
    vrg_ramp_type i_vel_accel, i_vel_decel, i_vel_qstop;
    vrg_jerk_type i_jerk;
    logic signed [31:0] o_ramp_output_speed, o_measured_speed, o_setpoint_speed, o_demand_pos;
    logic [15:0] o_statusword;
    logic o_jerk_active;
    logic [7:0] h_mode;
    logic h_halt;
    logic signed [31:0] h_dec;
    logic [7:0] modes [4] = '{MODE_POS, MODE_VEL, MODE_PVEL, 8'h00};
    int n_mismatch = 0;
    int samples_checked = 0;
    int seed = 32'h4362_2484;
    int k;
    int j;
    always #5 i_clk = ~i_clk;
    vrg_host u_host (.i_mode(h_mode), .i_halt(h_halt), .i_dec_rpm(h_dec), .o_mode(i_operating_mode_select),
        .o_controlword(i_controlword), .o_decel(i_vel_decel));
    vrg_ramp_gen DUT (.i_clk, .i_rst_n, .i_operating_mode_select, .i_controlword, .i_quick_stop_active,
        .i_target_speed, .i_speed_offset, .i_speed_mult, .i_speed_div, .i_vel_clamp, .i_vel_accel, .i_vel_decel,
        .i_vel_qstop, .i_max_profile_speed, .i_max_motor_speed, .i_profile_speed, .i_end_speed, .i_pos_approach,
        .i_prof_accel, .i_prof_decel, .i_qstop_decel, .i_max_accel, .i_max_decel, .i_profile_type, .i_jerk,
        .i_pos_range, .i_demand_pos, .i_measured_speed, .o_ramp_output_speed, .o_measured_speed,
        .o_setpoint_speed, .o_demand_pos, .o_statusword, .o_jerk_active);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    task automatic wait_speed(input logic signed [31:0] v, input int lim);
        int c;
        c = 0;
        while (o_ramp_output_speed !== v && c < lim) begin
            tick(1);
            c++;
        end
        check(o_ramp_output_speed, v);
        if (o_ramp_output_speed !== v) summarize();
    endtask
    // Clamp works on magnitude in user units, cap on rpm after scaling
    function automatic logic signed [31:0] exp_sp(input logic signed [31:0] t);
        logic signed [63:0] v;
        logic signed [63:0] m;
        logic signed [63:0] c;
        v = t + i_speed_offset;
        m = (v < 0) ? -v : v;
        c = (i_max_profile_speed < i_max_motor_speed) ? i_max_profile_speed : i_max_motor_speed;
        if (m < i_vel_clamp.lo) m = i_vel_clamp.lo;
        if (m > i_vel_clamp.hi) m = i_vel_clamp.hi;
        m = m * i_speed_mult / i_speed_div;
        if (m > c) m = c;
        return (v < 0) ? -m[31:0] : m[31:0];
    endfunction
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        h_mode = MODE_VEL;
        h_halt = 1'b0;
        h_dec = -32'sh05F5_E100;
        i_quick_stop_active = 1'b0;
        i_target_speed = 32'sh0000_0000;
        i_speed_offset = 32'sh0000_0000;
        i_speed_mult = 32'h0000_0001;
        i_speed_div = 32'h0000_0001;
        i_vel_clamp = '{32'sh0000_0014, 32'sh0000_07D0};
        i_vel_accel = '{32'h05F5_E100, ONE_SECOND};
        i_vel_qstop = '{32'h05F5_E100, ONE_SECOND};
        i_max_profile_speed = 32'h0000_C350;
        i_max_motor_speed = 32'h0000_C350;
        i_profile_speed = 32'h0000_C350;
        i_end_speed = 32'sh0000_0000;
        i_pos_approach = 1'b0;
        i_prof_accel = 32'h05F5_E100;
        i_prof_decel = 32'h05F5_E100;
        i_qstop_decel = 32'h05F5_E100;
        i_max_accel = 32'h05F5_E100;
        i_max_decel = 32'h05F5_E100;
        i_profile_type = PROF_TRAP;
        i_jerk = {4{32'h0000_0064}};
        i_pos_range = '{32'sh0000_0000, 32'sh0000_0000};
        i_demand_pos = 32'sh0000_0000;
        i_measured_speed = 32'sh0000_0000;
        tick(5);
        i_rst_n = 1'b1;
        i_target_speed = 32'sh0000_0064;
        tick(20);
        check(o_statusword[LIMIT_BIT], 1'b1);
        wait_speed(32'sh0000_0064, 130);
        tick(2);
        check(o_statusword, RST_STATUS);
        i_vel_accel = '{32'h02FA_F080, ONE_SECOND};
        i_target_speed = 32'sh0000_0096;
        tick(40);
        check(o_ramp_output_speed >= 32'sh0000_006E && o_ramp_output_speed <= 32'sh0000_007D, 1'b1);
        wait_speed(32'sh0000_0096, 150);
        i_vel_accel = '{32'h05F5_E100, ONE_SECOND};
        h_halt = 1'b1;
        wait_speed(32'sh0000_0000, 300);
        check(o_statusword, RST_STATUS);
        h_halt = 1'b0;
        wait_speed(32'sh0000_0096, 300);
        h_dec = 32'sh0000_0001;
        i_quick_stop_active = 1'b1;
        wait_speed(32'sh0000_0000, 300);
        i_quick_stop_active = 1'b0;
        h_dec = 32'sh05F5_E100;
        i_target_speed = 32'sh0000_0834;
        wait_speed(32'sh0000_07D0, 2100);
        check(o_statusword[LIMIT_BIT], 1'b1);
        i_max_motor_speed = 32'h0000_0BB8;
        for (k = 0; k < 24; k++) begin
            i_target_speed = (k < 2) ? k * 5 : $random(seed) % 32'sh0000_0BB8;
            i_speed_offset = $random(seed) % 32'sh0000_0008;
            i_speed_mult = 32'(1 + ($random(seed) & 32'h0000_0007));
            i_speed_div = 32'(1 + ($random(seed) & 32'h0000_0003));
            tick(3);
            check(o_setpoint_speed, exp_sp(i_target_speed));
        end
        i_speed_mult = 32'h0000_0001;
        i_speed_div = 32'h0000_0001;
        i_speed_offset = 32'sh0000_0000;
        i_max_motor_speed = 32'h0000_C350;
        for (k = 0; k < 4; k++) begin
            for (j = 0; j < 2; j++) begin
                h_mode = modes[k];
                i_profile_type = j ? PROF_JERK : PROF_TRAP;
                tick(4);
                check(o_jerk_active, j == 1 && modes[k] != MODE_VEL);
            end
        end
        i_profile_type = PROF_TRAP;
        h_mode = MODE_POS;
        i_pos_approach = 1'b1;
        i_end_speed = 32'sh0000_0032;
        tick(3);
        check(o_setpoint_speed, 32'sh0000_0032);
        wait_speed(32'sh0000_0032, 2500);
        i_max_accel = 32'h0098_9680;
        i_end_speed = 32'sh0000_0096;
        tick(50);
        check(o_ramp_output_speed <= 32'sh0000_0038, 1'b1);
        wait_speed(32'sh0000_0096, 1200);
        i_prof_decel = 32'h0000_0001;
        i_quick_stop_active = 1'b1;
        wait_speed(32'sh0000_0000, 300);
        i_quick_stop_active = 1'b0;
        for (k = 0; k < 16; k++) begin
            i_measured_speed = $random(seed);
            i_demand_pos = k[0] ? ($random(seed) & 32'sh0000_00FF) : $random(seed);
            if (k[0]) begin
                i_pos_range = '{32'sh0000_0000, 32'sh0000_0168};
            end else begin
                i_pos_range = '{32'sh0000_0000, 32'sh0000_0000};
            end
            tick(1);
            check(o_measured_speed, i_measured_speed);
            check(o_demand_pos, i_demand_pos);
        end
        i_demand_pos = 32'sh0000_0190;
        tick(1);
        check(!o_demand_pos[31] && o_demand_pos < 32'sh0000_0168, 1'b1);
        summarize();
    end
endmodule // vrg_ramp_gen_bench
`default_nettype wire
